//--- pkg/snkfr_regs.svh
// register offsets, fields, reset values and limits of the sink framing block
`ifndef SNKFR_REGS_SVH
`define SNKFR_REGS_SVH
`define SNKFR_CTRL_OFF 8'h00
`define SNKFR_CAL_OFF 8'h04
`define SNKFR_THR_OFF 8'h08
`define SNKFR_STAT_OFF 8'h0c
`define SNKFR_INT_OFF 8'h10
`define SNKFR_MASK_OFF 8'h14
`define SNKFR_CTRL_RST 32'h0000_1100
`define SNKFR_CAL_RST 32'h0000_0000
`define SNKFR_THR_RST 32'h0010_0008
`define SNKFR_EN_BIT 0
`define SNKFR_ERRLIM_LSB 4
`define SNKFR_TRAIN_LSB 8
`define SNKFR_MODE_LSB 12
`define SNKFR_REP_LSB 0
`define SNKFR_LEN_LSB 16
`define SNKFR_SET_LSB 0
`define SNKFR_CLR_LSB 16
`define SNKFR_TRAIN_WORDS 4'd10
`define SNKFR_LEVEL_MAX 10'd508
`define SNKFR_LEVEL_MIN 10'd1
`define SNKFR_INT_UNFRAME 0
`define SNKFR_INT_FRAME 1
`define SNKFR_INT_NFULL 2
`define SNKFR_INT_PARITY 3
`define SNKFR_NINT 4
`endif

//--- pkg/snkfr_pkg.sv
// types shared by the sink framing block
package snkfr_pkg;
  // one word seen on the receive link
  typedef struct packed {
    logic valid;
    logic ctrl;
    logic training;
    logic parity_err;
    logic [15:0] data;
  } snkfr_word_t;
  // flow control reactions
  typedef enum logic [1:0] {
    SNKFR_REACT_UNFRAME = 2'h0,
    SNKFR_REACT_SATISFIED = 2'h1,
    SNKFR_REACT_NORMAL = 2'h2,
    SNKFR_REACT_NORMAL2 = 2'h3
  } snkfr_react_t;
  // status channel sequencer
  typedef enum logic [1:0] {
    SNKFR_ST_FRAME,
    SNKFR_ST_CAL,
    SNKFR_ST_PARITY
  } snkfr_stat_t;
endpackage

//--- logic/snkfr_top.sv
// sink framing, flow control and status calendar with axi4-lite registers
`timescale 1ns/1ps
`include "snkfr_regs.svh"
module snkfr_top import snkfr_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic data_link_clock,
  input wire snkfr_word_t link_word,
  input wire logic status_write_clock,
  input wire logic [1:0] channel_status,
  input wire logic [9:0] fifo_free_level,
  output snkfr_word_t accepted_word,
  output logic receiver_unframed,
  output logic receive_fifo_nearly_full_n,
  output logic [8:0] calendar_slot,
  output logic [1:0] status_channel_out,
  output logic irq
);
  // registers
  logic [31:0] ctrl_r, cal_r, thr_r;
  logic [`SNKFR_NINT-1:0] int_stat_r, int_mask_r, int_set;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r;

  // axi write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_bvalid &&
        !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_r && !s_axi_bvalid &&
        !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r > `SNKFR_MASK_OFF ||
          aw_addr_r[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_go;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

  // merge write data into a register by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SNKFR_CTRL_RST;
      cal_r <= `SNKFR_CAL_RST;
      thr_r <= `SNKFR_THR_RST;
      int_mask_r <= '0;
    end else if (wr_go) begin
      case (aw_addr_r)
        `SNKFR_CTRL_OFF: ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
        `SNKFR_CAL_OFF: cal_r <= merge(cal_r, w_data_r, w_strb_r);
        `SNKFR_THR_OFF: thr_r <= merge(thr_r, w_data_r, w_strb_r);
        `SNKFR_MASK_OFF: int_mask_r <= w_data_r[`SNKFR_NINT-1:0];
        default: ;
      endcase
    end
  end

  // effective settings, zero or out of range forced to legal values
  logic enable;
  logic [3:0] err_limit, train_need;
  snkfr_react_t react;
  logic [9:0] set_raw, clr_raw, set_lvl, clr_lvl;
  assign enable = ctrl_r[`SNKFR_EN_BIT];
  assign err_limit = (ctrl_r[`SNKFR_ERRLIM_LSB +: 4] == 4'h0) ? 4'h1 :
    ctrl_r[`SNKFR_ERRLIM_LSB +: 4];
  assign train_need = (ctrl_r[`SNKFR_TRAIN_LSB +: 4] == 4'h0) ? 4'h1 :
    ctrl_r[`SNKFR_TRAIN_LSB +: 4];
  assign react = snkfr_react_t'(ctrl_r[`SNKFR_MODE_LSB +: 2]);
  assign set_raw = {1'b0, thr_r[`SNKFR_SET_LSB +: 9]};
  assign clr_raw = {1'b0, thr_r[`SNKFR_CLR_LSB +: 9]};
  assign set_lvl = (set_raw < `SNKFR_LEVEL_MIN) ? `SNKFR_LEVEL_MIN :
    (set_raw > `SNKFR_LEVEL_MAX) ? `SNKFR_LEVEL_MAX : set_raw;
  assign clr_lvl = (clr_raw < set_lvl) ? set_lvl :
    (clr_raw > `SNKFR_LEVEL_MAX) ? `SNKFR_LEVEL_MAX : clr_raw;

  // two-flop synchronisers for link clocks and the link word
  logic [1:0] dclk_s, sclk_s;
  logic dclk_d, sclk_d;
  snkfr_word_t word_s1, word_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dclk_s <= 2'h0;
      sclk_s <= 2'h0;
      dclk_d <= 1'b0;
      sclk_d <= 1'b0;
      word_s1 <= '0;
      word_s2 <= '0;
    end else begin
      dclk_s <= {dclk_s[0], data_link_clock};
      sclk_s <= {sclk_s[0], status_write_clock};
      dclk_d <= dclk_s[1];
      sclk_d <= sclk_s[1];
      word_s1 <= link_word;
      word_s2 <= word_s1;
    end
  end
  logic dclk_rise, sclk_rise;
  assign dclk_rise = dclk_s[1] && !dclk_d;
  assign sclk_rise = sclk_s[1] && !sclk_d;

  // framing: training pattern hunt and parity error run
  logic oof_r;
  logic [3:0] run_r, pat_r, perr_r;
  logic in_data_r;
  logic nf_r;
  snkfr_word_t w;
  assign w = word_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      oof_r <= 1'b1;
      run_r <= 4'h0;
      pat_r <= 4'h0;
      perr_r <= 4'h0;
      in_data_r <= 1'b0;
    end else if (dclk_rise && w.valid) begin
      if (!w.training) begin
        run_r <= 4'h0;
        pat_r <= 4'h0;
        in_data_r <= 1'b0;
      end else if (w.ctrl == in_data_r) begin
        // ten control words then ten data words, any slip restarts
        run_r <= w.ctrl ? 4'h1 : 4'h0;
        pat_r <= 4'h0;
        in_data_r <= 1'b0;
      end else if (run_r == `SNKFR_TRAIN_WORDS - 4'h1) begin
        run_r <= 4'h0;
        in_data_r <= !in_data_r;
        if (in_data_r) begin
          pat_r <= pat_r + 4'h1;
          if (oof_r && pat_r + 4'h1 >= train_need) begin
            oof_r <= 1'b0;
            perr_r <= 4'h0;
          end
        end
      end else begin
        run_r <= run_r + 4'h1;
      end
      if (!oof_r && w.ctrl && !w.training) begin
        if (w.parity_err) begin
          perr_r <= perr_r + 4'h1;
          if (perr_r + 4'h1 >= err_limit) begin
            oof_r <= 1'b1;
          end
        end else begin
          perr_r <= 4'h0;
        end
      end
    end
  end

  // accept data only in frame; receiver_unframed as seen outside
  logic unframed_nxt;
  assign unframed_nxt = oof_r ||
    (!nf_r && react == SNKFR_REACT_UNFRAME);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accepted_word <= '0;
      receiver_unframed <= 1'b1;
    end else begin
      receiver_unframed <= unframed_nxt;
      accepted_word <= '0;
      if (dclk_rise && w.valid && !w.ctrl && !w.training &&
        !unframed_nxt) begin
        accepted_word <= w;
      end
    end
  end

  // nearly full with hysteresis between set and clear levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nf_r <= 1'b1;
    end else if (nf_r && fifo_free_level <= set_lvl) begin
      nf_r <= 1'b0;
    end else if (!nf_r && fifo_free_level >= clr_lvl) begin
      nf_r <= 1'b1;
    end
  end
  assign receive_fifo_nearly_full_n = nf_r;

  // calendar settings captured on status write clock edges while disabled
  logic [7:0] cal_rep_r;
  logic [8:0] cal_len_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_rep_r <= 8'h00;
      cal_len_r <= 9'h000;
    end else if (sclk_rise && !enable) begin
      cal_rep_r <= cal_r[`SNKFR_REP_LSB +: 8];
      cal_len_r <= cal_r[`SNKFR_LEN_LSB +: 9];
    end
  end

  // status channel: framing, calendar passes, then parity
  snkfr_stat_t st_r;
  logic [7:0] rep_r;
  logic [1:0] dip_r, slot_val;
  always_comb begin
    slot_val = channel_status;
    if (!nf_r && react == SNKFR_REACT_SATISFIED) begin
      slot_val = 2'h2;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= SNKFR_ST_FRAME;
      rep_r <= 8'h00;
      calendar_slot <= 9'h000;
      dip_r <= 2'h3;
      status_channel_out <= 2'h3;
    end else if (sclk_rise) begin
      if (unframed_nxt || !enable) begin
        st_r <= SNKFR_ST_FRAME;
        status_channel_out <= 2'h3;
      end else begin
        case (st_r)
          SNKFR_ST_FRAME: begin
            status_channel_out <= 2'h3;
            st_r <= SNKFR_ST_CAL;
            rep_r <= 8'h00;
            calendar_slot <= 9'h000;
            dip_r <= 2'h3;
          end
          SNKFR_ST_CAL: begin
            status_channel_out <= slot_val;
            dip_r <= dip_r ^ slot_val;
            if (calendar_slot == cal_len_r) begin
              calendar_slot <= 9'h000;
              if (rep_r == cal_rep_r) begin
                st_r <= SNKFR_ST_PARITY;
              end else begin
                rep_r <= rep_r + 8'h01;
              end
            end else begin
              calendar_slot <= calendar_slot + 9'h001;
            end
          end
          SNKFR_ST_PARITY: begin
            status_channel_out <= dip_r;
            st_r <= SNKFR_ST_FRAME;
          end
          default: st_r <= SNKFR_ST_FRAME;
        endcase
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  logic oof_d, nf_d, perr_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oof_d <= 1'b1;
      nf_d <= 1'b1;
    end else begin
      oof_d <= unframed_nxt;
      nf_d <= nf_r;
    end
  end
  assign perr_evt = dclk_rise && w.valid && w.ctrl && !w.training &&
    w.parity_err && !oof_r && enable;
  always_comb begin
    int_set = '0;
    int_set[`SNKFR_INT_UNFRAME] = unframed_nxt && !oof_d;
    int_set[`SNKFR_INT_FRAME] = !unframed_nxt && oof_d;
    int_set[`SNKFR_INT_NFULL] = !nf_r && nf_d;
    int_set[`SNKFR_INT_PARITY] = perr_evt;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_go && aw_addr_r == `SNKFR_INT_OFF) begin
        int_stat_r <= (int_stat_r & ~w_data_r[`SNKFR_NINT-1:0]) | int_set;
      end else begin
        int_stat_r <= int_stat_r | int_set;
      end
      irq <= |(int_stat_r & int_mask_r);
    end
  end

  // axi read channel, one cycle to answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `SNKFR_CTRL_OFF: s_axi_rdata <= ctrl_r;
          `SNKFR_CAL_OFF: s_axi_rdata <= cal_r;
          `SNKFR_THR_OFF: s_axi_rdata <= thr_r;
          `SNKFR_STAT_OFF: s_axi_rdata <= {24'h000000, perr_r, 2'h0,
            !nf_r, unframed_nxt};
          `SNKFR_INT_OFF: s_axi_rdata <= {28'h0000000, int_stat_r};
          `SNKFR_MASK_OFF: s_axi_rdata <= {28'h0000000, int_mask_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // snkfr_top

//--- tb/snkfr_tx_model.sv
// far-side transmitter model driving the receive link
`timescale 1ns/1ps
module snkfr_tx_model import snkfr_pkg::*; (
  output logic data_link_clock,
  output snkfr_word_t link_word
);
  // link clock idles low between bursts
  initial begin
    data_link_clock = 1'b0;
    link_word = '0;
  end
  // one word per link clock, inverted (not valid) once released;
  // word and rising edge sit 1 ns off the core clock edges
  task automatic send(input snkfr_word_t w);
    #1 link_word = w;
    #80 data_link_clock = 1'b1;
    #79 data_link_clock = 1'b0;
    link_word = ~w;
  endtask
  // whole patterns of ten control and ten data training words
  task automatic train(input int n);
    for (int p = 0; p < n; p++)
      for (int i = 0; i < 20; i++)
        send('{1'b1, i < 10, 1'b1, 1'b0, 16'h0f0f});
  endtask
  // plain control word, with or without a parity fault
  task automatic ctl(input logic err);
    send('{1'b1, 1'b1, 1'b0, err, 16'h0000});
  endtask
endmodule // snkfr_tx_model

//--- tb/snkfr_top_properties.sv
// port assertions for the sink framing block
`timescale 1ns/1ps
module snkfr_checker import snkfr_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [9:0] fifo_free_level,
  input wire snkfr_word_t accepted_word,
  input wire logic receiver_unframed,
  input wire logic receive_fifo_nearly_full_n,
  input wire logic [1:0] status_channel_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  start_unframed_a:
    assert property ($rose(aresetn) |-> receiver_unframed)
    else $error("sink framed right after reset");
  no_accept_a:
    assert property (receiver_unframed [*3] |-> !accepted_word.valid)
    else $error("word accepted while unframed");
  unframed_idle_a:
    assert property (receiver_unframed [*8] ##0 $changed(status_channel_out)
      |-> status_channel_out == 2'h3)
    else $error("status not idle while unframed");
  accept_pulse_a:
    assert property (accepted_word.valid |=> !accepted_word.valid)
    else $error("accept strobe longer than one cycle");
  nf_empty_a:
    assert property ((fifo_free_level == 10'h0) [*2]
      |=> !receive_fifo_nearly_full_n)
    else $error("no nearly full with empty fifo space");
  nf_roomy_a:
    assert property ((fifo_free_level > 10'd508) [*2]
      |=> receive_fifo_nearly_full_n)
    else $error("nearly full above clear limit");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  unmapped_read_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // snkfr_checker
bind snkfr_top snkfr_checker u_snkfr_checker (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
  .fifo_free_level, .accepted_word, .receiver_unframed,
  .receive_fifo_nearly_full_n, .status_channel_out);

//--- tb/snkfr_top_tb.sv
// self-checking bench for the sink framing block
`timescale 1ns/1ps
`include "snkfr_regs.svh"
module snkfr_top_tb import snkfr_pkg::*; ;
  logic aclk = 1'b0, status_write_clock = 1'b0, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, n_acc = '0;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_link_clock, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, status_channel_out;
  logic [1:0] channel_status;
  logic [9:0] fifo_free_level;
  logic [15:0] acc_data;
  logic [8:0] calendar_slot, slot_max;
  logic receiver_unframed, receive_fifo_nearly_full_n;
  snkfr_word_t link_word, accepted_word;
  int checks = 0, n_mismatch = 0, k, runs;
  // core clock and an unrelated status clock
  always #2 aclk = ~aclk;
  always #80 status_write_clock = ~status_write_clock;
  snkfr_top u_snkfr_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_link_clock,
    .link_word, .status_write_clock, .channel_status, .fifo_free_level,
    .accepted_word, .receiver_unframed, .receive_fifo_nearly_full_n,
    .calendar_slot, .status_channel_out, .irq);
  snkfr_tx_model u_tx (.data_link_clock, .link_word);
  // count accepted words
  always @(posedge aclk)
    if (accepted_word.valid === 1'b1) begin
      n_acc <= n_acc + 1;
      acc_data <= accepted_word.data;
    end
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one register access, held until each channel is taken
  task automatic axi(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_arvalid <= rd;
    s_axi_awvalid <= !rd;
    s_axi_wvalid <= !rd;
    s_axi_bready <= !rd;
    s_axi_rready <= rd;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (rd ? s_axi_rvalid : s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    r = rd ? s_axi_rresp : s_axi_bresp;
    if (n == 50) begin
      n_mismatch++;
      print_verdict();
    end
    repeat (3) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    axi(1'b1, a, 32'h0);
  endtask
  // set free space and slot status, then let them settle
  task automatic lvl(input logic [9:0] v, input logic [1:0] c);
    @(posedge aclk);
    fifo_free_level <= v;
    channel_status <= c;
    repeat (8) @(posedge aclk);
  endtask
  task automatic t_reset;
    chk("unframed", receiver_unframed, 1'b1);
    rd(`SNKFR_CTRL_OFF);
    chk("ctrl reset", q, 32'h0000_1100);
    rd(`SNKFR_THR_OFF);
    chk("thr reset", q, 32'h0010_0008);
    rd(8'h18);
    chk("unmapped resp", r, 2'h2);
    wr(8'h18, 32'h0000_0001);
    chk("unmapped write", r, 2'h2);
    // only byte one of the control word may change
    s_axi_wstrb <= 4'h2;
    wr(`SNKFR_CTRL_OFF, 32'hffff_ffff);
    s_axi_wstrb <= 4'hf;
    rd(`SNKFR_CTRL_OFF);
    chk("byte strobe", q, 32'h0000_ff00);
    $display("test reset done");
  endtask
  task automatic t_train;
    wr(`SNKFR_CTRL_OFF, 32'h0000_2231);
    u_tx.train(1);
    chk("unframed early", receiver_unframed, 1'b1);
    u_tx.train(1);
    chk("framed", receiver_unframed, 1'b0);
    u_tx.send('{1'b1, 1'b0, 1'b0, 1'b0, 16'h5a3c});
    chk("accepted count", n_acc, 32'd1);
    chk("accepted data", acc_data, 16'h5a3c);
    u_tx.send('{1'b1, 1'b0, 1'b1, 1'b0, 16'h1111});
    chk("training not data", n_acc, 32'd1);
    $display("test training done");
  endtask
  task automatic t_parity;
    for (int i = 0; i < 5; i++)
      u_tx.ctl(i != 2);
    chk("framed after broken run", receiver_unframed, 1'b0);
    u_tx.ctl(1'b1);
    chk("unframed at limit", receiver_unframed, 1'b1);
    u_tx.send('{1'b1, 1'b0, 1'b0, 1'b0, 16'h0001});
    chk("refused word", n_acc, 32'd1);
    rd(`SNKFR_INT_OFF);
    chk("unframe event", q[0], 1'b1);
    chk("irq masked", irq, 1'b0);
    wr(`SNKFR_MASK_OFF, 32'h1);
    chk("irq raised", irq, 1'b1);
    wr(`SNKFR_INT_OFF, 32'hf);
    chk("irq cleared", irq, 1'b0);
    wr(`SNKFR_MASK_OFF, 32'h0);
    wr(`SNKFR_CTRL_OFF, 32'h0000_2001);
    u_tx.train(1);
    chk("zero count frames", receiver_unframed, 1'b0);
    u_tx.ctl(1'b1);
    chk("zero limit unframes", receiver_unframed, 1'b1);
    $display("test parity done");
  endtask
  task automatic t_nfull;
    wr(`SNKFR_CTRL_OFF, 32'h0000_1001);
    wr(`SNKFR_THR_OFF, 32'h01ff_0000);
    u_tx.train(1);
    lvl(10'd2, 2'h0);
    chk("above set", receive_fifo_nearly_full_n, 1'b1);
    lvl(10'd1, 2'h0);
    chk("at set", receive_fifo_nearly_full_n, 1'b0);
    lvl(10'd507, 2'h0);
    chk("below clear", receive_fifo_nearly_full_n, 1'b0);
    lvl(10'd0, 2'h0);
    k = 0;
    for (int i = 0; i < 9; i++) begin
      @(negedge status_write_clock);
      k += int'(status_channel_out === 2'h2);
    end
    chk("satisfied slots", k, 3);
    chk("mode 1 framed", receiver_unframed, 1'b0);
    lvl(10'd508, 2'h0);
    chk("at clear", receive_fifo_nearly_full_n, 1'b1);
    wr(`SNKFR_CTRL_OFF, 32'h0000_0001);
    lvl(10'd1, 2'h0);
    chk("mode 0 unframes", receiver_unframed, 1'b1);
    lvl(10'h200, 2'h0);
    wr(`SNKFR_THR_OFF, 32'h0010_0008);
    $display("test nearly full done");
  endtask
  task automatic t_cal;
    wr(`SNKFR_CTRL_OFF, 32'h0);
    wr(`SNKFR_CAL_OFF, 32'h0002_0001);
    repeat (100) @(posedge aclk);
    wr(`SNKFR_CTRL_OFF, 32'h0000_3001);
    u_tx.train(1);
    lvl(10'd1, 2'h1);
    chk("mode 3 framed", receiver_unframed, 1'b0);
    k = 0;
    runs = 0;
    slot_max = 9'h000;
    for (int i = 0; i < 40 && runs < 3; i++) begin
      @(negedge status_write_clock);
      if (calendar_slot > slot_max) slot_max = calendar_slot;
      if (status_channel_out === 2'h1) k++;
      else if (k != 0) begin
        if (runs++ > 0) chk("calendar slots", k, 6);
        k = 0;
      end
    end
    chk("calendar frames", runs, 3);
    chk("calendar slot top", slot_max, 9'h002);
    $display("test calendar done");
  endtask
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    channel_status = 2'h1;
    fifo_free_level = 10'h100;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_train();
    t_parity();
    t_nfull();
    t_cal();
    print_verdict();
  end
endmodule // snkfr_top_tb
